// *** bench/ssg_illum_model.sv ***
// Purpose: light driver side model, measures each sync pulse
// Assumes: frame pin rise marks the frame, same clock as the block
// Notes: offset counts edges from the pin rise to the light rise
module ssg_illum_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic frame_start_pin,
  input wire logic illum_en,
  input wire logic [1:0] illum_color,
  output logic seen,
  output logic [23:0] ofs,
  output logic [23:0] wid,
  output logic [1:0] col,
  output int count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic frame_q; // Last sampled frame pin
  logic lit_q; // Last sampled light enable
  logic [23:0] since_q; // Edges since frame pin rise
  logic [23:0] run_q; // Edges with light on
  // Pulse measurement; a stuck-on light never ends, so no width is reported
  always_ff @(posedge clk) begin
    frame_q <= frame_start_pin;
    lit_q <= illum_en;
    seen <= 1'b0;
    since_q <= (frame_start_pin && !frame_q) ? 24'h000001 : since_q + 24'h000001;
    if (reset) begin
      count <= 0;
      run_q <= 24'h000000;
    end else if (illum_en && !lit_q) begin
      ofs <= since_q;
      col <= illum_color;
      run_q <= 24'h000001;
    end else if (illum_en) begin
      run_q <= run_q + 24'h000001;
    end else if (lit_q) begin
      wid <= run_q;
      seen <= 1'b1;
      count <= count + 1;
    end
  end
endmodule

// *** bench/ssg_sync_top_bench.sv ***
// Purpose: self-checking bench for the stereo sync pulse block
// Assumes: short counts loaded in place of real frame timing
// Notes: driver notes each expected pulse, monitor pops and compares
module ssg_sync_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, stereo_active, frame_start_pin, left_eye_pin, light_mode, load;
  logic [23:0] width_cyc, base_cyc, delta_cyc, frame_cyc;
  logic [1:0] color_sel, illum_color, col;
  logic ir_sync_o, ir_sync_oe_n, illum_en, param_err, rate_err, seen;
  logic [23:0] ofs, wid;
  int count, failures, compares, cyc;
  logic [49:0] notes[$]; // Expected colour, offset, width
  logic [31:0] rng; // Xorshift state
  logic [23:0] w; // Pulse width of the current frame
  ssg_sync_top i_dut (.clk(clk), .reset(reset), .stereo_active(stereo_active),
    .frame_start_pin(frame_start_pin), .left_eye_pin(left_eye_pin), .light_mode(light_mode),
    .load(load), .width_cyc(width_cyc), .base_cyc(base_cyc), .delta_cyc(delta_cyc),
    .frame_cyc(frame_cyc), .color_sel(color_sel), .ir_sync_o(ir_sync_o),
    .ir_sync_oe_n(ir_sync_oe_n), .illum_en(illum_en), .illum_color(illum_color),
    .param_err(param_err), .rate_err(rate_err));
  ssg_illum_model i_model (.clk(clk), .reset(reset), .frame_start_pin(frame_start_pin),
    .illum_en(illum_en), .illum_color(illum_color), .seen(seen), .ofs(ofs), .wid(wid),
    .col(col), .count(count));
  // Free-running 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Fixed-seed xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Single value comparison
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // Counts, verdict and end of run
  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Latch a set of counts and colour
  task automatic ld(input logic [23:0] wv, bv, dv, input logic [1:0] c);
    @(posedge clk);
    width_cyc <= wv;
    base_cyc <= bv;
    delta_cyc <= dv;
    color_sel <= c;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  // Monitor: each measured pulse takes the oldest note
  always @(posedge clk) begin
    if (!reset && seen) begin
      if (notes.size() == 0) begin
        chk("spare pulse", 24'h000000, 24'h000001);
      end else begin
        chk("offset", notes[0][47:24], ofs);
        chk("width", notes[0][23:0], wid);
        chk("colour", {22'h000000, notes[0][49:48]}, {22'h000000, col});
        void'(notes.pop_front());
      end
    end
  end
  // Main sequence
  initial begin
    rng = 32'h000038B1;
    {stereo_active, frame_start_pin, left_eye_pin, light_mode, load} = 5'h00;
    {width_cyc, base_cyc, delta_cyc, frame_cyc, color_sel} = '0;
    reset = 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("illum reset", 24'h000000, {23'h000000, illum_en});
    // Range edges of the loaded counts
    ld(24'h001964, 24'h01E849, 24'h0080E8, 2'h0);
    chk("param ok", 24'h000000, {23'h000000, param_err});
    ld(24'h001387, 24'h01E849, 24'h0080E8, 2'h0);
    chk("width low", 24'h000001, {23'h000000, param_err});
    ld(24'h001964, 24'h01E848, 24'h0080E8, 2'h0);
    chk("base low", 24'h000001, {23'h000000, param_err});
    ld(24'h001964, 24'h01E849, 24'h009F2F, 2'h0);
    chk("delta high", 24'h000001, {23'h000000, param_err});
    ld(24'h001964, 24'h01E849, 24'h0080E8, 2'h0);
    chk("param clear", 24'h000000, {23'h000000, param_err});
    // Light mode: six short frames, every colour code
    light_mode <= 1'b1;
    stereo_active <= 1'b1;
    frame_cyc <= 24'h000190;
    for (int k = 0; k < 6; k++) begin
      rng = xs(rng);
      w = 24'h00000A + {20'h00000, rng[3:0]};
      ld(w, 24'h000064, 24'h00001E, k[1:0]);
      // alternate offset
      // Pulse ends base, or base plus delta, before frame end; five edges of pin and pipe latency
      notes.push_back({(k == 2) ? 2'h0 : k[1:0],
        24'h000195 - 24'h000064 - w - ((k % 2) ? 24'h00001E : 24'h000000), w});
      frame_start_pin <= 1'b1;
      left_eye_pin <= k[0];
      repeat (10) @(posedge clk);
      frame_start_pin <= 1'b0;
      repeat (386) @(posedge clk);
    end
    chk("unmatched notes", 24'h000000, 24'(notes.size()));
    chk("pulse count", 24'h000006, 24'(count));
    chk("rate flag", 24'h000001, {23'h000000, rate_err});
    // IR mode follows the eye level while stereo runs
    light_mode <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      rng = xs(rng);
      left_eye_pin <= rng[0];
      repeat (8) @(posedge clk);
      chk("ir level", {23'h000000, rng[0]}, {23'h000000, ir_sync_o});
      chk("ir drive", 24'h000000, {23'h000000, ir_sync_oe_n});
    end
    stereo_active <= 1'b0;
    repeat (8) @(posedge clk);
    chk("ir idle", 24'h000001, {23'h000000, ir_sync_oe_n});
    report_and_stop();
  end
endmodule

// *** hw/ssg_defines.svh ***
`ifndef SSG_DEFINES_SVH
`define SSG_DEFINES_SVH
// Purpose: timing constants for the stereo sync pulse block
// Assumes: 250 MHz system clock, 4 ns period
// Notes: times in ns, counts derived by rounding as documented

`define SSG_CLK_PERIOD_NS 4
// System clock rate in Hz, the reference for the frame rate window
`define SSG_CLK_HZ 32'h0EE6B280
// Pulse width window and nominal width at 120 Hz input
`define SSG_WIDTH_MIN_NS 20000
`define SSG_WIDTH_MAX_NS 32000
`define SSG_WIDTH_NOM_NS 26000
`define SSG_WIDTH_MIN_CYC ((`SSG_WIDTH_MIN_NS + `SSG_CLK_PERIOD_NS - 1) / `SSG_CLK_PERIOD_NS)
`define SSG_WIDTH_MAX_CYC (`SSG_WIDTH_MAX_NS / `SSG_CLK_PERIOD_NS)
`define SSG_WIDTH_NOM_CYC (`SSG_WIDTH_NOM_NS / `SSG_CLK_PERIOD_NS)
// Base offset, strictly above 500 us
`define SSG_BASE_MIN_NS 500000
`define SSG_BASE_MIN_CYC (`SSG_BASE_MIN_NS / `SSG_CLK_PERIOD_NS + 1)
// Delta offset window and nominal at 120 Hz
`define SSG_DELTA_MIN_NS 128000
`define SSG_DELTA_MAX_NS 163000
`define SSG_DELTA_NOM_NS 132000
`define SSG_DELTA_MIN_CYC ((`SSG_DELTA_MIN_NS + `SSG_CLK_PERIOD_NS - 1) / `SSG_CLK_PERIOD_NS)
`define SSG_DELTA_MAX_CYC (`SSG_DELTA_MAX_NS / `SSG_CLK_PERIOD_NS)
`define SSG_DELTA_NOM_CYC (`SSG_DELTA_NOM_NS / `SSG_CLK_PERIOD_NS)
// Quiet interval after the pulse, strictly above 2000 us
`define SSG_TAIL_MIN_NS 2000000
`define SSG_TAIL_MIN_CYC (`SSG_TAIL_MIN_NS / `SSG_CLK_PERIOD_NS + 1)
// Supported input frame rate range in Hz
`define SSG_RATE_MIN_HZ 98
`define SSG_RATE_MAX_HZ 122
// Colour select codes
`define SSG_COLOR_RED 2'h0
`define SSG_COLOR_GREEN 2'h1
`define SSG_COLOR_BLUE 2'h2
`endif

// *** hw/ssg_pkg.sv ***
// Purpose: types shared by the stereo sync pulse block
// Assumes: nothing beyond the defines header
// Notes: states of the pulse scheduler
package ssg_pkg;
  // Pulse scheduler states
  typedef enum logic [1:0] {
    SSG_IDLE,
    SSG_WAIT,
    SSG_PULSE
  } ssg_state_e;
  typedef logic [23:0] ssg_cnt_t;
endpackage

// *** hw/ssg_pulse_timer.sv ***
// Purpose: delay-then-width one-shot for the light sync pulse
// Assumes: delay and width at least one cycle
// Notes: a start while busy is ignored
module ssg_pulse_timer (
  input wire logic clk,
  input wire logic reset,
  ssg_timer_if.tmr t
);
  ssg_pkg::ssg_state_e state_q;
  logic [23:0] cnt_q;
  logic done_q;

  // Delay then pulse sequencing
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ssg_pkg::SSG_IDLE;
      cnt_q <= 24'h000000;
    end else begin
      case (state_q)
        ssg_pkg::SSG_IDLE: begin
          if (t.start) begin
            state_q <= ssg_pkg::SSG_WAIT;
            cnt_q <= t.delay;
          end
        end
        ssg_pkg::SSG_WAIT: begin
          if (cnt_q <= 24'h000001) begin
            state_q <= ssg_pkg::SSG_PULSE;
            cnt_q <= t.width;
          end else begin
            cnt_q <= cnt_q - 24'h000001;
          end
        end
        default: begin
          if (cnt_q <= 24'h000001) begin
            state_q <= ssg_pkg::SSG_IDLE;
          end else begin
            cnt_q <= cnt_q - 24'h000001;
          end
        end
      endcase
    end
  end

  // One-cycle completion strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == ssg_pkg::SSG_PULSE) && (cnt_q <= 24'h000001);
    end
  end

  assign t.busy = (state_q != ssg_pkg::SSG_IDLE);
  assign t.fire = (state_q == ssg_pkg::SSG_PULSE);
  assign t.done = done_q;
endmodule

// *** hw/ssg_sync_top.sv ***
// Purpose: stereo glasses sync, IR pin and light pulse scheduling
// Assumes: frame_start/left_eye from pins, synchronised here
// Notes: timing counts are inputs loaded per frame rate
`include "ssg_defines.svh"

module ssg_sync_top #(
  parameter int unsigned CNT_W = 24
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic stereo_active,
  input wire logic frame_start_pin,
  input wire logic left_eye_pin,
  input wire logic light_mode,
  input wire logic load,
  input wire logic [23:0] width_cyc,
  input wire logic [23:0] base_cyc,
  input wire logic [23:0] delta_cyc,
  input wire logic [23:0] frame_cyc,
  input wire logic [1:0] color_sel,
  output logic ir_sync_o,
  output logic ir_sync_oe_n,
  output logic illum_en,
  output logic [1:0] illum_color,
  output logic param_err,
  output logic rate_err
);
  // Three-stage pin synchronisers
  logic [2:0] fs_sync_q;
  logic [2:0] le_sync_q;
  logic fs_level_q;
  logic le_level_q;
  logic frame_evt;
  // Loaded per-rate counts
  logic [23:0] width_q;
  logic [23:0] base_q;
  logic [23:0] delta_q;
  logic [23:0] total_q;
  logic [1:0] color_q;
  // Offset toggle, flips every frame while stereo active
  logic alt_q;
  // Frame period measure, cycles since last frame
  logic [23:0] period_q;
  logic in_frame_q;
  ssg_timer_if tif ();

  // Range check of one programmed set of counts
  function automatic logic counts_bad(input logic [23:0] w, input logic [23:0] b, input logic [23:0] d);
    logic bad;
    bad = 1'b0;
    if (w < 24'(`SSG_WIDTH_MIN_CYC) || w > 24'(`SSG_WIDTH_MAX_CYC)) begin
      bad = 1'b1;
    end
    if (b < 24'(`SSG_BASE_MIN_CYC)) begin
      bad = 1'b1;
    end
    if (d < 24'(`SSG_DELTA_MIN_CYC) || d > 24'(`SSG_DELTA_MAX_CYC)) begin
      bad = 1'b1;
    end
    counts_bad = bad;
  endfunction

  // Pin synchronisers; only stages 1 and 2 are compared
  always_ff @(posedge clk) begin
    if (reset) begin
      fs_sync_q <= 3'h0;
      le_sync_q <= 3'h0;
    end else begin
      fs_sync_q <= {fs_sync_q[1:0], frame_start_pin};
      le_sync_q <= {le_sync_q[1:0], left_eye_pin};
    end
  end

  // Accept a pin change once two late stages agree
  always_ff @(posedge clk) begin
    if (reset) begin
      fs_level_q <= 1'b0;
      le_level_q <= 1'b0;
    end else begin
      if (fs_sync_q[1] == fs_sync_q[2]) begin
        fs_level_q <= fs_sync_q[2];
      end
      if (le_sync_q[1] == le_sync_q[2]) begin
        le_level_q <= le_sync_q[2];
      end
    end
  end

  assign frame_evt = (fs_sync_q[1] == fs_sync_q[2]) && fs_sync_q[2] && !fs_level_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      width_q <= 24'(`SSG_WIDTH_NOM_CYC);
      base_q <= 24'(`SSG_BASE_MIN_CYC);
      delta_q <= 24'(`SSG_DELTA_NOM_CYC);
      color_q <= `SSG_COLOR_RED;
    end else if (load) begin
      width_q <= width_cyc;
      base_q <= base_cyc;
      delta_q <= delta_cyc;
      // colour select, blue falls back to red
      color_q <= (color_sel == `SSG_COLOR_BLUE) ? `SSG_COLOR_RED : color_sel;
    end
  end

  // total offset derived, never set alone
  always_ff @(posedge clk) begin
    if (reset) begin
      total_q <= 24'(`SSG_BASE_MIN_CYC + `SSG_DELTA_NOM_CYC);
    end else begin
      total_q <= base_q + delta_q;
    end
  end

  // Parameter range flag, sticky until next load
  always_ff @(posedge clk) begin
    if (reset) begin
      param_err <= 1'b0;
    end else if (load) begin
      param_err <= counts_bad(width_cyc, base_cyc, delta_cyc);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      alt_q <= 1'b0;
    end else if (frame_evt && stereo_active) begin
      alt_q <= !alt_q;
    end
  end

  // one pulse launched per frame, offset before frame end
  always_comb begin
    tif.start = frame_evt && stereo_active && light_mode && !tif.busy;
    // alternate offset measured back from subframe end
    if (alt_q) begin
      tif.delay = (frame_cyc > total_q + width_q) ? frame_cyc - total_q - width_q : 24'h000001;
    end else begin
      tif.delay = (frame_cyc > base_q + width_q) ? frame_cyc - base_q - width_q : 24'h000001;
    end
    tif.width = width_q;
  end

  ssg_pulse_timer u_timer (
    .clk(clk),
    .reset(reset),
    .t(tif)
  );

  // light enable only during the pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      illum_en <= 1'b0;
      illum_color <= `SSG_COLOR_RED;
    end else begin
      illum_en <= tif.fire && light_mode && stereo_active;
      illum_color <= color_q;
    end
  end

  // IR pin follows eye, driven while stereo active and light_mode low
  always_ff @(posedge clk) begin
    if (reset) begin
      ir_sync_o <= 1'b0;
      ir_sync_oe_n <= 1'b1;
    end else begin
      ir_sync_o <= stereo_active && !light_mode && le_level_q;
      ir_sync_oe_n <= !(stereo_active && !light_mode);
    end
  end

  // frame period tracking for the rate window
  always_ff @(posedge clk) begin
    if (reset) begin
      period_q <= 24'h000000;
      in_frame_q <= 1'b0;
    end else if (frame_evt) begin
      period_q <= 24'h000000;
      in_frame_q <= 1'b1;
    end else if (period_q != 24'hFFFFFF) begin
      period_q <= period_q + 24'h000001;
    end
  end

  // rate error when frame period leaves the window
  always_ff @(posedge clk) begin
    if (reset) begin
      rate_err <= 1'b0;
    end else if (frame_evt && in_frame_q && stereo_active) begin
      rate_err <= (32'(period_q) + 32'h1) * `SSG_RATE_MIN_HZ > `SSG_CLK_HZ ||
                  (32'(period_q) + 32'h1) * `SSG_RATE_MAX_HZ < `SSG_CLK_HZ;
    end
  end

  // Assertions
  property p_width;
    @(posedge clk) disable iff (reset)
      $rose(illum_en) |-> illum_en [*8];
  endproperty
  a_width: assert property (p_width) else $error("illum pulse too short");

  property p_illum_off;
    @(posedge clk) disable iff (reset)
      illum_en |-> $past(tif.fire);
  endproperty
  a_illum_off: assert property (p_illum_off) else $error("illum without pulse");

  property p_total;
    @(posedge clk) disable iff (reset)
      $stable(base_q) && $stable(delta_q) && !load |=> total_q == base_q + delta_q;
  endproperty
  a_total: assert property (p_total) else $error("total not base plus delta");

  property p_alt;
    @(posedge clk) disable iff (reset)
      frame_evt && stereo_active |=> alt_q != $past(alt_q);
  endproperty
  a_alt: assert property (p_alt) else $error("offset toggle stuck");

  property p_one_pulse;
    @(posedge clk) disable iff (reset)
      tif.start |=> !tif.start;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("double launch");

  property p_ir;
    @(posedge clk) disable iff (reset)
      !stereo_active |=> ir_sync_oe_n && !ir_sync_o;
  endproperty
  a_ir: assert property (p_ir) else $error("IR pin active without stereo");

  property p_color;
    @(posedge clk) disable iff (reset)
      illum_en |-> illum_color != `SSG_COLOR_BLUE;
  endproperty
  a_color: assert property (p_color) else $error("blue sync pulse");

  property p_load;
    @(posedge clk) disable iff (reset)
      load |=> width_q == $past(width_cyc) && base_q == $past(base_cyc);
  endproperty
  a_load: assert property (p_load) else $error("counts not loaded");

  // Launch steps: a start, then the timer counts down with the light off
  sequence s_start;
    tif.start;
  endsequence

  sequence s_wait;
    tif.busy && !tif.fire;
  endsequence

  property p_launch;
    @(posedge clk) disable iff (reset)
      s_start |=> s_wait;
  endproperty
  a_launch: assert property (p_launch) else $error("timer not counting after launch");

  property p_done;
    @(posedge clk) disable iff (reset)
      tif.done |-> !tif.busy && $past(tif.fire);
  endproperty
  a_done: assert property (p_done) else $error("pulse end out of step");

  property p_evt_once;
    @(posedge clk) disable iff (reset)
      frame_evt |=> !frame_evt;
  endproperty
  a_evt_once: assert property (p_evt_once) else $error("frame event repeated");

  property p_ir_follow;
    @(posedge clk) disable iff (reset)
      stereo_active && !light_mode |=> ir_sync_o == $past(le_level_q) && !ir_sync_oe_n;
  endproperty
  a_ir_follow: assert property (p_ir_follow) else $error("IR pin not following eye");

  property p_illum_ir_off;
    @(posedge clk) disable iff (reset)
      !light_mode |=> !illum_en;
  endproperty
  a_illum_ir_off: assert property (p_illum_ir_off) else $error("light on in IR mode");

  property p_width_low;
    @(posedge clk) disable iff (reset)
      load && width_cyc < 24'(`SSG_WIDTH_MIN_CYC) |=> param_err;
  endproperty
  a_width_low: assert property (p_width_low) else $error("short width not flagged");

  property p_base_low;
    @(posedge clk) disable iff (reset)
      load && base_cyc < 24'(`SSG_BASE_MIN_CYC) |=> param_err;
  endproperty
  a_base_low: assert property (p_base_low) else $error("low base not flagged");

  property p_delta_high;
    @(posedge clk) disable iff (reset)
      load && delta_cyc > 24'(`SSG_DELTA_MAX_CYC) |=> param_err;
  endproperty
  a_delta_high: assert property (p_delta_high) else $error("long delta not flagged");
endmodule

// *** hw/ssg_timer_if.sv ***
// Purpose: carrier between scheduler and its pulse timer
// Assumes: one clock domain
// Notes: start is a one-cycle pulse
interface ssg_timer_if;
  logic start;
  logic [23:0] delay;
  logic [23:0] width;
  logic busy;
  logic fire;
  logic done;
  modport ctrl (output start, output delay, output width, input busy, input fire, input done);
  modport tmr (input start, input delay, input width, output busy, output fire, output done);
endinterface
